// ### hw/ext_irq_defs.svh
// Constants for the external interrupt noise filter block
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH
`define CTRL_ADDR          6'h37
`define CTRL_RESET         8'h00
`define CTRL_WMASK         8'hce
`define BIT_B_LENGTH       7
`define BIT_A_FUNCTION     6
`define BIT_D_EDGE         3
`define BIT_C_EDGE         2
`define BIT_B_EDGE         1
`define PIN_COUNT          5
`define CNT_W              8
// Filter acceptance times, in periods of the high frequency clock
`define ACCEPT_AE_FC       7
`define ACCEPT_B_SHORT_FC  49
`define ACCEPT_B_LONG_FC   193
`define ACCEPT_CD_FC       25
// Acceptance in slow modes, in tenths of a low frequency period
`define ACCEPT_SLOW_FS_X10 35
`define SLOW_TICKS         (`ACCEPT_SLOW_FS_X10 / 10)
// Low frequency period, in high frequency periods (20 MHz / 32.768 kHz)
`define FS_DIV             10'd610
`define FS_DIV_W           10
`endif

// ### hw/ext_irq_pkg.sv
// Types shared by the external interrupt noise filter block
package ext_irq_pkg;
    typedef logic [7:0] ctrl_t;
    typedef logic [4:0] pin_vec_t;
    typedef logic [7:0] count_t;
endpackage

// ### hw/external_irq_noise_filter.sv
// External interrupt pins: noise filters, edge select, request latches
`timescale 1ns/1ps
`include "ext_irq_defs.svh"

// What this block does
// - Five external request pins, each with its own digital noise filter.
// - Pins b, c, d have selectable edge; pins a and e use falling edges.
// - After reset the shared pin a works as a port, not interrupt input.
// - With pin a function bit clear, its falling edge never sets its latch.
// - Normal modes: pins a, e reject under 2 fc, accept 7 fc or more.
// - Normal modes: pin b rejects under 15 or 63 fc, accepts 49 or 193.
// - Normal modes: pins c, d reject under 7 fc, accept 25 fc or more.
// - Slow and sleep modes: all filters reject under 1 fs, accept 3.5 fs.
// - Clean edge sets latch within acceptance time plus 6 fs.
// - Pin d request needs master enable, its enable, and pin source selected.
// - Control bit 7 picks pin b filter: 0 long, 1 short.
// - Control bit 6: 0 port use, 1 interrupt use of shared pin.
// - Control bits 3, 2, 1 pick edges of d, c, b: 0 rising, 1 falling.
// - New pin b filter length acts within 26 fc of the write.
// - Shared pin driven as output may raise spurious requests; mask first.
// - Control register at 37h resets to zero; bits 5, 4, 0 unused.
// - A latch holds until accepted, reset, or cleared by software.
module external_irq_noise_filter (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              slow_mode,
    input  wire logic              ext_irq_pin_a,
    input  wire logic              ext_irq_pin_b,
    input  wire logic              ext_irq_pin_c,
    input  wire logic              ext_irq_pin_d,
    input  wire logic              ext_irq_pin_e,
    input  wire logic [5:0]        sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire ext_irq_pkg::ctrl_t sfr_wdata,
    input  wire logic              master_irq_enable,
    input  wire logic              pin_a_irq_enable,
    input  wire logic              pin_b_irq_enable,
    input  wire logic              pin_c_irq_enable,
    input  wire logic              pin_d_irq_enable,
    input  wire logic              pin_e_irq_enable,
    input  wire logic              latch14_source_select,
    input  wire ext_irq_pkg::pin_vec_t irq_accept,
    input  wire logic              latch_clear_wr,
    input  wire ext_irq_pkg::pin_vec_t latch_clear_data,
    output ext_irq_pkg::ctrl_t     sfr_rdata,
    output ext_irq_pkg::pin_vec_t  request_latch,
    output ext_irq_pkg::pin_vec_t  irq_request,
    output logic                   pin_a_function_select
);
    import ext_irq_pkg::*;

    logic                  rst_meta_r;
    logic                  rst_sync_r;
    ctrl_t                 ctrl_r;
    ctrl_t                 rdata_r;
    logic [`FS_DIV_W-1:0]  fs_div_r;
    logic                  fs_tick;
    logic                  tick;
    pin_vec_t              pins;
    pin_vec_t              filt_r;
    pin_vec_t              prev_r;
    pin_vec_t              edge_hit;
    pin_vec_t              latch_r;
    pin_vec_t              latch_nxt;
    pin_vec_t              enables;
    pin_vec_t              falling_sel;
    count_t                cnt_r [`PIN_COUNT];
    count_t                lim   [`PIN_COUNT];
    logic                  pin_b_filter_length;
    logic                  pin_b_edge_select;
    logic                  pin_c_edge_select;
    logic                  pin_d_edge_select;
    logic                  ctrl_wr;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign ctrl_wr = sfr_wr && (sfr_addr == `CTRL_ADDR);

    // Control register
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ctrl_r <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= sfr_wdata & `CTRL_WMASK;
        end
    end

    assign pin_b_filter_length   = ctrl_r[`BIT_B_LENGTH];
    assign pin_a_function_select = ctrl_r[`BIT_A_FUNCTION];
    assign pin_d_edge_select     = ctrl_r[`BIT_D_EDGE];
    assign pin_c_edge_select     = ctrl_r[`BIT_C_EDGE];
    assign pin_b_edge_select     = ctrl_r[`BIT_B_EDGE];

    // Read data, unused bits read zero
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rdata_r <= 8'h00;
        end else if (sfr_rd) begin
            rdata_r <= (sfr_addr == `CTRL_ADDR) ? ctrl_r : 8'h00;
        end
    end
    assign sfr_rdata = rdata_r;

    // Low frequency sampling enable
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            fs_div_r <= '0;
        end else if (fs_div_r == `FS_DIV - 10'd1) begin
            fs_div_r <= '0;
        end else begin
            fs_div_r <= fs_div_r + 10'd1;
        end
    end
    assign fs_tick = (fs_div_r == `FS_DIV - 10'd1);
    assign tick    = slow_mode ? fs_tick : 1'b1;

    assign pins = {ext_irq_pin_e, ext_irq_pin_d, ext_irq_pin_c,
                   ext_irq_pin_b, ext_irq_pin_a};

    // Pins a and e always falling; b, c, d as selected
    assign falling_sel = {1'b1, pin_d_edge_select, pin_c_edge_select,
                          pin_b_edge_select, 1'b1};

    // Acceptance counts; bit change acts on the next sample
    always_comb begin
        if (slow_mode) begin
            for (int k = 0; k < `PIN_COUNT; k++) begin
                lim[k] = count_t'(`SLOW_TICKS);
            end
        end else begin
            lim[0] = count_t'(`ACCEPT_AE_FC);
            lim[1] = pin_b_filter_length ? count_t'(`ACCEPT_B_SHORT_FC)
                                         : count_t'(`ACCEPT_B_LONG_FC);
            lim[2] = count_t'(`ACCEPT_CD_FC);
            lim[3] = count_t'(`ACCEPT_CD_FC);
            lim[4] = count_t'(`ACCEPT_AE_FC);
        end
    end

    // One sampled counter filter per pin
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g++) begin : gen_filter
            always_ff @(posedge ref_clk or negedge rst_sync_r) begin
                if (!rst_sync_r) begin
                    cnt_r[g]  <= '0;
                    filt_r[g] <= 1'b1;
                    prev_r[g] <= 1'b1;
                end else begin
                    prev_r[g] <= filt_r[g];
                    if (tick) begin
                        if (pins[g] == filt_r[g]) begin
                            cnt_r[g] <= '0;
                        end else if (cnt_r[g] + 8'd1 >= lim[g]) begin
                            cnt_r[g]  <= '0;
                            filt_r[g] <= pins[g];
                        end else begin
                            cnt_r[g] <= cnt_r[g] + 8'd1;
                        end
                    end
                end
            end
            assign edge_hit[g] = falling_sel[g] ? (prev_r[g] & ~filt_r[g])
                                                : (~prev_r[g] & filt_r[g]);
        end
    endgenerate

    // Request latches: a new edge wins over a clear in the same cycle
    always_comb begin
        latch_nxt = latch_r & ~irq_accept;
        if (latch_clear_wr) begin
            latch_nxt = latch_nxt & latch_clear_data;
        end
        latch_nxt = latch_nxt | (edge_hit & {4'hf, pin_a_function_select});
    end

    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            latch_r <= '0;
        end else begin
            latch_r <= latch_nxt;
        end
    end
    assign request_latch = latch_r;

    // Masking also covers spurious port-driven edges on the shared pin
    assign enables = {pin_e_irq_enable, pin_d_irq_enable & ~latch14_source_select,
                      pin_c_irq_enable, pin_b_irq_enable,
                      pin_a_irq_enable & pin_a_function_select};
    assign irq_request = latch_r & enables & {`PIN_COUNT{master_irq_enable}};

    a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        ctrl_wr |=> ctrl_r == ($past(sfr_wdata) & `CTRL_WMASK))
        else $error("control register write not stored");

    a_port_reset: assert property (@(posedge ref_clk)
        $rose(rst_sync_r) |-> !pin_a_function_select && ctrl_r == `CTRL_RESET)
        else $error("control register not cleared by reset");

    a_pin_a_gate: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !pin_a_function_select |=> !$rose(latch_r[0]) || $past(pin_a_function_select))
        else $error("pin a latch set in port mode");

    a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        latch_r[2] && !irq_accept[2] && !(latch_clear_wr && !latch_clear_data[2])
        |=> latch_r[2])
        else $error("pin c latch dropped without clear");

    a_edge_latch: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        prev_r[4] && !filt_r[4] |=> latch_r[4])
        else $error("pin e filtered edge did not set latch");

    a_short_reject: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !slow_mode && pins[4] == filt_r[4] ##1 pins[4] != filt_r[4] ##1 pins[4] == filt_r[4]
        |-> $stable(filt_r[4]))
        else $error("pin e one cycle pulse passed filter");

    a_cd_count: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !slow_mode && !$past(slow_mode) |-> cnt_r[2] < count_t'(`ACCEPT_CD_FC))
        else $error("pin c counter past acceptance");

    a_b_length: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !slow_mode && !$past(slow_mode) && !pin_b_filter_length && !$past(pin_b_filter_length)
        && tick && pins[1] != filt_r[1] && cnt_r[1] == count_t'(`ACCEPT_B_SHORT_FC - 1)
        |=> filt_r[1] != pins[1] || cnt_r[1] == count_t'(`ACCEPT_B_SHORT_FC)
        || cnt_r[1] == '0)
        else $error("pin b long filter accepted too early");

    a_slow_limit: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        slow_mode |-> lim[0] == count_t'(`SLOW_TICKS) && lim[1] == count_t'(`SLOW_TICKS)
        && lim[3] == count_t'(`SLOW_TICKS))
        else $error("slow mode acceptance count wrong");

    a_d_request: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        irq_request[3] |-> master_irq_enable && pin_d_irq_enable && !latch14_source_select
        && latch_r[3])
        else $error("pin d request without enables");

    // Register read port
    a_read_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        sfr_rd && sfr_addr == `CTRL_ADDR |=> sfr_rdata == $past(ctrl_r))
        else $error("control register read data wrong");

    a_read_other: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        sfr_rd && sfr_addr != `CTRL_ADDR |=> sfr_rdata == 8'h00)
        else $error("other address read not zero");

    // Filter lengths and sampling
    a_long_select: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !slow_mode && !pin_b_filter_length |-> lim[1] == count_t'(`ACCEPT_B_LONG_FC))
        else $error("pin b long filter not selected");

    a_pin_b_short: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !slow_mode && pin_b_filter_length && tick && pins[1] != filt_r[1]
        && cnt_r[1] == count_t'(`ACCEPT_B_SHORT_FC - 1) |=> filt_r[1] == $past(pins[1]))
        else $error("pin b short filter did not accept");

    a_pin_e_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !slow_mode && tick && pins[4] != filt_r[4]
        && cnt_r[4] < count_t'(`ACCEPT_AE_FC - 1) |=> filt_r[4] == $past(filt_r[4]))
        else $error("pin e filter flipped before acceptance");

    a_pin_a_accept: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !slow_mode && tick && pins[0] != filt_r[0]
        && cnt_r[0] == count_t'(`ACCEPT_AE_FC - 1) |=> filt_r[0] == $past(pins[0]))
        else $error("pin a filter did not accept");

    a_slow_sample: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        slow_mode && !fs_tick |=> filt_r == $past(filt_r))
        else $error("filter moved between slow samples");

    // Edge selection and latches
    a_rise_only: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !pin_c_edge_select && prev_r[2] && !filt_r[2] && !latch_r[2] |=> !latch_r[2])
        else $error("pin c falling edge set latch in rising mode");

    a_rise_latch: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !pin_c_edge_select && !prev_r[2] && filt_r[2] |=> latch_r[2])
        else $error("pin c rising edge did not set latch");

    a_pin_d_fall: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        pin_d_edge_select && prev_r[3] && !filt_r[3] |=> latch_r[3])
        else $error("pin d falling edge did not set latch");

    a_pin_a_latch: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        pin_a_function_select && prev_r[0] && !filt_r[0] |=> latch_r[0])
        else $error("pin a falling edge did not set latch");

    a_accept_clear: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        irq_accept[2] && !edge_hit[2] |=> !latch_r[2])
        else $error("pin c latch not cleared by accept");

    a_clear_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        latch_clear_wr && !latch_clear_data[3] && !edge_hit[3] |=> !latch_r[3])
        else $error("pin d latch not cleared by write");

    a_master_gate: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !master_irq_enable |-> irq_request == 5'h00)
        else $error("request raised with master enable clear");
endmodule

// ### verif/external_irq_noise_filter_test.sv
// Self-checking bench for the external interrupt noise filter block
`timescale 1ns/1ps
`include "ext_irq_defs.svh"
module external_irq_noise_filter_test;
    import ext_irq_pkg::*;
    typedef struct packed {pin_vec_t l; pin_vec_t r; logic f;} snap_t;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b1;
    logic        slow_mode = 1'b0;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic        master = 1'b0;
    logic        sel = 1'b0;
    logic        latch_clear_wr = 1'b0;
    logic        snap = 1'b0;
    logic        rd_d1 = 1'b0;
    logic        rd_d2 = 1'b0;
    logic        fsel;
    logic [5:0]  sfr_addr = 6'h00;
    logic [31:0] seed = 32'h4bfc286e;
    logic [31:0] r;
    ctrl_t       sfr_wdata = 8'h00;
    ctrl_t       cur = 8'h00;
    ctrl_t       sfr_rdata;
    pin_vec_t    en = 5'h00;
    pin_vec_t    irq_accept = 5'h00;
    pin_vec_t    latch_clear_data = 5'h1f;
    pin_vec_t    prev = 5'h00;
    pin_vec_t    pins;
    pin_vec_t    request_latch;
    pin_vec_t    irq_request;
    snap_t       s;
    int          n_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    int          tp[14] = '{0, 0, 4, 4, 1, 1, 2, 2, 3, 3, 1, 1, 0, 2};
    int          tw[14] = '{1, 7, 1, 7, 14, 49, 6, 25, 6, 25, 62, 193, 7, 25};
    bit          ta[14] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1};
    ctrl_t       rq[$];
    pin_vec_t    lq[$];
    snap_t       sq[$];

    irq_pin_source irq_pin_source_i (.ref_clk(ref_clk), .pins(pins));
    external_irq_noise_filter external_irq_noise_filter_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .slow_mode(slow_mode),
        .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .ext_irq_pin_c(pins[2]),
        .ext_irq_pin_d(pins[3]), .ext_irq_pin_e(pins[4]), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .master_irq_enable(master), .pin_a_irq_enable(en[0]), .pin_b_irq_enable(en[1]),
        .pin_c_irq_enable(en[2]), .pin_d_irq_enable(en[3]), .pin_e_irq_enable(en[4]),
        .latch14_source_select(sel), .irq_accept(irq_accept),
        .latch_clear_wr(latch_clear_wr), .latch_clear_data(latch_clear_data),
        .sfr_rdata(sfr_rdata), .request_latch(request_latch),
        .irq_request(irq_request), .pin_a_function_select(fsel));

    always #25 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic pin_vec_t exp_req(input pin_vec_t l);
        return l & {en[4], en[3] & ~sel, en[2:1], en[0] & cur[6]} & {5{master}};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (lq.size() != 0) begin
            n_errors++;
            $display("[FAIL] latch set expected %0d more seen 0", lq.size());
        end
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watcher: takes the oldest note off a queue whenever a result appears
    always @(negedge ref_clk) begin
        rd_d1 <= sfr_rd;
        rd_d2 <= rd_d1;
        prev <= request_latch;
        if (rd_d2) chk("ctrl read", rq.pop_front(), sfr_rdata);
        if ((request_latch & ~prev) != 5'h00)
            chk("latch set", {3'h0, lq.size() ? lq.pop_front() : 5'h00}, {3'h0, request_latch});
        if (snap) begin
            s = sq.pop_front();
            chk("latch", {3'h0, s.l}, {3'h0, request_latch});
            chk("request", {3'h0, s.r}, {3'h0, irq_request});
            chk("pin a function", {7'h0, s.f}, {7'h0, fsel});
        end
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [5:0] a, input ctrl_t d);
        @(negedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(negedge ref_clk) sfr_wr <= 1'b0;
        if (a == `CTRL_ADDR) cur = d & `CTRL_WMASK;
    endtask

    task automatic rd(input logic [5:0] a, input ctrl_t exp);
        rq.push_back(exp);
        @(negedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(negedge ref_clk) sfr_rd <= 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic snapchk(input pin_vec_t l);
        sq.push_back('{l, exp_req(l), cur[6]});
        snap <= 1'b1;
        @(negedge ref_clk) snap <= 1'b0;
    endtask

    task automatic pl(input int p, input int w, input bit acc);
        if (acc) lq.push_back(5'h01 << p);
        irq_pin_source_i.pulse(p, w);
        repeat (2 * w + 12) @(negedge ref_clk);
        irq_accept <= 5'h1f;
        @(negedge ref_clk) irq_accept <= 5'h00;
        snapchk(5'h00);
    endtask

    task automatic clr(input pin_vec_t d, input pin_vec_t left);
        latch_clear_wr <= 1'b1;
        latch_clear_data <= d;
        @(negedge ref_clk) latch_clear_wr <= 1'b0;
        snapchk(left);
    endtask

    initial begin
        // Reset falls at time zero so no flop meets the first edge unknown
        reset_n <= 1'b0;
        repeat (8) @(negedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
        rd(`CTRL_ADDR, 8'h00);
        snapchk(5'h00);
        wr(`CTRL_ADDR, 8'hff);
        rd(`CTRL_ADDR, 8'hce);
        wr(6'h36, 8'h00);
        rd(`CTRL_ADDR, 8'hce);
        rd(6'h36, 8'h00);
        for (int i = 0; i < 14; i++) begin
            // Short filter, falling edges first; then long filter, rising, port mode
            if (i == 10) begin
                wr(`CTRL_ADDR, 8'h00);
                repeat (26) @(negedge ref_clk);
            end
            pl(tp[i], tw[i], ta[i]);
        end
        r = xs();
        pl(2, 1 + int'(r[2:0] % 6), 1'b0);
        lq.push_back(5'h08);
        irq_pin_source_i.pulse(3, 25);
        repeat (62) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            master <= r[0] | (i < 2);
            sel <= r[1] & (i != 0);
            en <= r[6:2] | {5{i < 2}};
            @(negedge ref_clk);
            snapchk(5'h08);
        end
        clr(5'h1f, 5'h08);
        clr(5'h17, 5'h00);
        slow_mode <= 1'b1;
        pl(4, 300, 1'b0);
        pl(4, 2440, 1'b1);
        report_and_stop();
    end
endmodule

// ### verif/irq_pin_source.sv
// Model of the external sources that drive the five request pins
`timescale 1ns/1ps
module irq_pin_source (
    input  wire logic             ref_clk,
    output ext_irq_pkg::pin_vec_t pins
);
    import ext_irq_pkg::*;
    // Sources idle high, so falling-edge pins see no edge at start
    initial pins = 5'h1f;
    // One clean low pulse of whole clocks, driven off the sampling edge
    task automatic pulse(input int idx, input int width);
        @(negedge ref_clk) pins[idx] <= 1'b0;
        repeat (width) @(negedge ref_clk);
        pins[idx] <= 1'b1;
    endtask
endmodule
